// *** design/ctsup_pkg.sv ***
/*
 Shared constants and types for the CT circuit supervision block:
 register indices, field positions, reset values, scaling and timing.
 Assumes every user of it names items as ctsup_pkg::name.
*/
package ctsup_pkg;

	// Operating modes of the function
	typedef enum logic [2:0] {MODE_ON, MODE_BLOCKED, MODE_TEST, MODE_TEST_BLOCKED, MODE_OFF} ctsup_mode_type;
	// Function status, computed or forced
	typedef enum logic [1:0] {STAT_NORMAL, STAT_ALARM, STAT_BLOCKED} ctsup_status_type;
	// Residual source choice
	typedef enum logic [1:0] {RES_NONE, RES_ONE, RES_TWO} ctsup_ressel_type;

	// Register indices on the plain port
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_HIGH_LIMIT = 4'h1;
	localparam logic [3:0] ADDR_LOW_LIMIT = 4'h2;
	localparam logic [3:0] ADDR_MINMAX_RATIO = 4'h3;
	localparam logic [3:0] ADDR_SEQ_RATIO = 4'h4;
	localparam logic [3:0] ADDR_SUM_DIFF = 4'h5;
	localparam logic [3:0] ADDR_DELAY = 4'h6;
	localparam logic [3:0] ADDR_COMMAND = 4'h7;
	localparam logic [3:0] ADDR_STATUS = 4'h8;
	localparam logic [3:0] ADDR_COMP_RE = 4'h9;
	localparam logic [3:0] ADDR_COMP_IM = 4'hA;
	localparam logic [3:0] ADDR_TIMER = 4'hB;

	// Control register fields
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_FORCE_LSB = 3;
	localparam int CTRL_RESSEL_LSB = 5;
	localparam int CTRL_POLARITY_BIT = 7;
	localparam int CTRL_WIDTH = 8;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// Command register: compensation request bit
	localparam int CMD_COMP_BIT = 0;

	// Status register fields
	localparam int STAT_CODE_LSB = 0;
	localparam int STAT_ALARM_BIT = 2;
	localparam int STAT_TEST_ALARM_BIT = 3;
	localparam int STAT_COND_LSB = 4;
	localparam int STAT_COMP_PEND_BIT = 10;

	// Setting reset values, currents in 0.01 x In, ratios in 0.01 %
	localparam logic [15:0] HIGH_LIMIT_RESET = 16'h0078;
	localparam logic [15:0] LOW_LIMIT_RESET = 16'h000A;
	localparam logic [15:0] MINMAX_RATIO_RESET = 16'h03E8;
	localparam logic [15:0] SEQ_RATIO_RESET = 16'h1324;
	localparam logic [15:0] SUM_DIFF_RESET = 16'h000A;

	// Timing: samples arrive on a fixed base, delay counts in the same step
	localparam int SAMPLE_BASE_MS = 5;
	localparam int DELAY_STEP_MS = 5;
	localparam int DELAY_DEFAULT_MS = 500;
	localparam int DELAY_WIDTH = 19;
	localparam logic [18:0] DELAY_RESET = 19'(DELAY_DEFAULT_MS / DELAY_STEP_MS);

	// Hysteresis factors in percent of the limit
	localparam logic [7:0] PCT_FULL = 8'h64;
	localparam logic [7:0] PCT_DROP = 8'h61;
	localparam logic [7:0] PCT_RISE = 8'h67;
	// Full scale of the ratio settings (100.00 %)
	localparam logic [15:0] RATIO_FULL = 16'h2710;
	// sqrt(3)/2 in Q15 for the sequence operator
	localparam logic [15:0] SQRT3_HALF_Q15 = 16'h6EDA;
	localparam int Q_SHIFT = 15;

endpackage

// *** design/ctsup_sequence.sv ***
/*
 Sequence and phasor-sum stage: from the three phase phasors it forms
 the squared positive and negative sequence magnitudes (scaled by 9)
 and the plain phase sum. Results register one cycle after start.
 Assumes phasor inputs are stable while start is high.
*/
`timescale 1ns/100ps
`default_nettype none

module ctsup_sequence (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic start,
	input wire logic signed [15:0] aRe,
	input wire logic signed [15:0] aIm,
	input wire logic signed [15:0] bRe,
	input wire logic signed [15:0] bIm,
	input wire logic signed [15:0] cRe,
	input wire logic signed [15:0] cIm,
	output logic done,
	output logic [39:0] posSq,
	output logic [39:0] negSq,
	output logic signed [17:0] sumRe,
	output logic signed [17:0] sumIm
);

	// Rotation constant as a signed operand
	logic signed [16:0] kSigned;
	// Q15 partial products
	logic signed [34:0] posReW, posImW, negReW, negImW;
	// Back to input units
	logic signed [19:0] posRe, posIm, negRe, negIm;

	assign kSigned = $signed({1'b0, ctsup_pkg::SQRT3_HALF_Q15});

	// Rotate b and c by a and a squared and sum with a
	always_comb begin
		posReW = 35'(aRe <<< ctsup_pkg::Q_SHIFT) - 35'(bRe <<< (ctsup_pkg::Q_SHIFT - 1))
			- 35'(kSigned * bIm) - 35'(cRe <<< (ctsup_pkg::Q_SHIFT - 1)) + 35'(kSigned * cIm);
		posImW = 35'(aIm <<< ctsup_pkg::Q_SHIFT) + 35'(kSigned * bRe)
			- 35'(bIm <<< (ctsup_pkg::Q_SHIFT - 1)) - 35'(kSigned * cRe) - 35'(cIm <<< (ctsup_pkg::Q_SHIFT - 1));
		negReW = 35'(aRe <<< ctsup_pkg::Q_SHIFT) - 35'(bRe <<< (ctsup_pkg::Q_SHIFT - 1))
			+ 35'(kSigned * bIm) - 35'(cRe <<< (ctsup_pkg::Q_SHIFT - 1)) - 35'(kSigned * cIm);
		negImW = 35'(aIm <<< ctsup_pkg::Q_SHIFT) - 35'(kSigned * bRe)
			- 35'(bIm <<< (ctsup_pkg::Q_SHIFT - 1)) + 35'(kSigned * cRe) - 35'(cIm <<< (ctsup_pkg::Q_SHIFT - 1));
		posRe = 20'(posReW >>> ctsup_pkg::Q_SHIFT);
		posIm = 20'(posImW >>> ctsup_pkg::Q_SHIFT);
		negRe = 20'(negReW >>> ctsup_pkg::Q_SHIFT);
		negIm = 20'(negImW >>> ctsup_pkg::Q_SHIFT);
	end

	// Register squared magnitudes and the phase sum
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			done <= 1'b0;
			posSq <= 40'h00_0000_0000;
			negSq <= 40'h00_0000_0000;
			sumRe <= 18'sh0_0000;
			sumIm <= 18'sh0_0000;
		end else begin
			done <= start;
			if (start) begin
				posSq <= 40'(posRe * posRe) + 40'(posIm * posIm);
				negSq <= 40'(negRe * negRe) + 40'(negIm * negIm);
				sumRe <= 18'(aRe) + 18'(bRe) + 18'(cRe);
				sumIm <= 18'(aIm) + 18'(bIm) + 18'(cIm);
			end
		end
	end

endmodule

`default_nettype wire

// *** design/ctsup_top.sv ***
/*
 CT circuit supervision: watches phase and residual fundamentals, each
 sample set marked by a one-cycle strobe every 5 ms, and raises an alarm
 when all enabled conditions hold for the set delay. Registers sit on a
 plain port with read data one cycle after the read strobe.
 Assumes all inputs are synchronous to core_clk.

*/
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/100ps
`default_nettype none

module ctsup_top (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [3:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [31:0] regRdData,
	input wire logic sampleStrobe,
	input wire logic [15:0] phase_a_fundamental,
	input wire logic [15:0] phase_b_fundamental,
	input wire logic [15:0] phase_c_fundamental,
	input wire logic signed [15:0] phaseARe,
	input wire logic signed [15:0] phaseAIm,
	input wire logic signed [15:0] phaseBRe,
	input wire logic signed [15:0] phaseBIm,
	input wire logic signed [15:0] phaseCRe,
	input wire logic signed [15:0] phaseCIm,
	input wire logic signed [15:0] residualOneRe,
	input wire logic signed [15:0] residualOneIm,
	input wire logic signed [15:0] residualTwoRe,
	input wire logic signed [15:0] residualTwoIm,
	input wire logic stageForceEnable,
	output logic alarmOut,
	output logic testAlarmOut,
	output logic [1:0] statusOut
);

	// Scaled compare a*100 > b*pct, used for every limit with hysteresis
	function automatic logic scaledAbove(input logic [15:0] a, input logic [15:0] b, input logic [7:0] pct);
		scaledAbove = (24'(a) * 24'(ctsup_pkg::PCT_FULL)) > (24'(b) * 24'(pct));
	endfunction

	// Scaled compare a*100 < b*pct
	function automatic logic scaledBelow(input logic [15:0] a, input logic [15:0] b, input logic [7:0] pct);
		scaledBelow = (24'(a) * 24'(ctsup_pkg::PCT_FULL)) < (24'(b) * 24'(pct));
	endfunction

	// Static settings, one copy only, no setting group bank
	logic [7:0] ctrl_q;
	logic [15:0] highLimit_q, lowLimit_q, minmaxRatio_q, seqRatio_q, sumDiff_q;
	logic [18:0] delay_q;
	// Compensation request waiting for the next evaluation
	logic compPending_q;
	// Captured natural unbalance
	logic signed [19:0] compRe_q, compIm_q;

	// Latched sample set
	logic [15:0] mag_q [3];
	logic signed [15:0] aRe_q, aIm_q, bRe_q, bIm_q, cRe_q, cIm_q, resRe_q, resIm_q;
	logic latched_q;

	// Per-phase hysteresis state
	logic [2:0] overHigh_q, aboveLow_q, belowLow_q;
	// Condition vector, delay timer and detection
	logic [5:0] cond_q;
	logic [18:0] timer_q;
	logic detected_q;

	// Decoded settings
	ctsup_pkg::ctsup_mode_type modeSel;
	ctsup_pkg::ctsup_ressel_type resSel;
	logic [1:0] forceVal;
	logic subtractRes;
	logic [15:0] magIn [3];

	// Sequence stage results
	logic seqDone;
	logic [39:0] posSq, negSq;
	logic signed [17:0] sumRe, sumIm;

	// Evaluation terms
	logic signed [19:0] rawRe, rawIm, diffRe, diffIm;
	logic [15:0] minMag, maxMag;
	logic [5:0] condNow;
	logic funcActive, modeBlocked, modeTest;
	ctsup_pkg::ctsup_status_type computedStatus, finalStatus;

	always_comb begin
		modeSel = ctsup_pkg::ctsup_mode_type'(ctrl_q[ctsup_pkg::CTRL_MODE_LSB +: 3]);
		resSel = ctsup_pkg::ctsup_ressel_type'(ctrl_q[ctsup_pkg::CTRL_RESSEL_LSB +: 2]);
		forceVal = ctrl_q[ctsup_pkg::CTRL_FORCE_LSB +: 2];
		subtractRes = ctrl_q[ctsup_pkg::CTRL_POLARITY_BIT];
	end

	assign magIn[0] = phase_a_fundamental;
	assign magIn[1] = phase_b_fundamental;
	assign magIn[2] = phase_c_fundamental;

	// Register writes; settings are static, none follow a setting group
	// single static settings
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl_q <= ctsup_pkg::CTRL_RESET;
			highLimit_q <= ctsup_pkg::HIGH_LIMIT_RESET;
			lowLimit_q <= ctsup_pkg::LOW_LIMIT_RESET;
			minmaxRatio_q <= ctsup_pkg::MINMAX_RATIO_RESET;
			seqRatio_q <= ctsup_pkg::SEQ_RATIO_RESET;
			sumDiff_q <= ctsup_pkg::SUM_DIFF_RESET;
			delay_q <= ctsup_pkg::DELAY_RESET;
		end else if (regWrite) begin
			if (regAddr == ctsup_pkg::ADDR_CTRL) begin
				ctrl_q <= regWrData[ctsup_pkg::CTRL_WIDTH-1:0];
			end else if (regAddr == ctsup_pkg::ADDR_HIGH_LIMIT) begin
				highLimit_q <= regWrData[15:0];
			end else if (regAddr == ctsup_pkg::ADDR_LOW_LIMIT) begin
				lowLimit_q <= regWrData[15:0];
			end else if (regAddr == ctsup_pkg::ADDR_MINMAX_RATIO) begin
				minmaxRatio_q <= regWrData[15:0];
			end else if (regAddr == ctsup_pkg::ADDR_SEQ_RATIO) begin
				seqRatio_q <= regWrData[15:0];
			end else if (regAddr == ctsup_pkg::ADDR_SUM_DIFF) begin
				sumDiff_q <= regWrData[15:0];
			end else if (regAddr == ctsup_pkg::ADDR_DELAY) begin
				delay_q <= regWrData[ctsup_pkg::DELAY_WIDTH-1:0];
			end
		end
	end

	// Latch a sample set on the strobe; residual picked here
	// 5 ms sample sets
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			latched_q <= 1'b0;
			aRe_q <= 16'sh0000;
			aIm_q <= 16'sh0000;
			bRe_q <= 16'sh0000;
			bIm_q <= 16'sh0000;
			cRe_q <= 16'sh0000;
			cIm_q <= 16'sh0000;
			resRe_q <= 16'sh0000;
			resIm_q <= 16'sh0000;
		end else begin
			latched_q <= sampleStrobe;
			if (sampleStrobe) begin
				aRe_q <= phaseARe;
				aIm_q <= phaseAIm;
				bRe_q <= phaseBRe;
				bIm_q <= phaseBIm;
				cRe_q <= phaseCRe;
				cIm_q <= phaseCIm;
				if (resSel == ctsup_pkg::RES_ONE) begin
					resRe_q <= residualOneRe;
					resIm_q <= residualOneIm;
				end else if (resSel == ctsup_pkg::RES_TWO) begin
					resRe_q <= residualTwoRe;
					resIm_q <= residualTwoIm;
				end else begin
					resRe_q <= 16'sh0000;
					resIm_q <= 16'sh0000;
				end
			end
		end
	end

	// Per-phase magnitude latch and limit hysteresis
	for (genvar p = 0; p < 3; p++) begin : gPhase
		always_ff @(posedge core_clk or posedge sys_rst) begin
			if (sys_rst) begin
				mag_q[p] <= 16'h0000;
			end else if (sampleStrobe) begin
				mag_q[p] <= magIn[p];
			end
		end

		// Hysteresis updates once per latched sample
		// drop 97, rise 103 percent
		always_ff @(posedge core_clk or posedge sys_rst) begin
			if (sys_rst) begin
				overHigh_q[p] <= 1'b0;
				aboveLow_q[p] <= 1'b0;
				belowLow_q[p] <= 1'b0;
			end else if (latched_q) begin
				// Over the upper limit, released below 97 %
				if (!overHigh_q[p]) begin
					overHigh_q[p] <= scaledAbove(mag_q[p], highLimit_q, ctsup_pkg::PCT_FULL);
				end else begin
					overHigh_q[p] <= !scaledBelow(mag_q[p], highLimit_q, ctsup_pkg::PCT_DROP);
				end
				// Above the lower limit, released below 97 %
				if (!aboveLow_q[p]) begin
					aboveLow_q[p] <= scaledAbove(mag_q[p], lowLimit_q, ctsup_pkg::PCT_FULL);
				end else begin
					aboveLow_q[p] <= !scaledBelow(mag_q[p], lowLimit_q, ctsup_pkg::PCT_DROP);
				end
				// Below the lower limit, released above 103 %
				if (!belowLow_q[p]) begin
					belowLow_q[p] <= scaledBelow(mag_q[p], lowLimit_q, ctsup_pkg::PCT_FULL);
				end else begin
					belowLow_q[p] <= !scaledAbove(mag_q[p], lowLimit_q, ctsup_pkg::PCT_RISE);
				end
			end
		end
	end

	// Sequence currents from full phasors, so channel angles count
	// phasor sequence stage
	ctsup_sequence uSequence (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.start(latched_q),
		.aRe(aRe_q),
		.aIm(aIm_q),
		.bRe(bRe_q),
		.bIm(bIm_q),
		.cRe(cRe_q),
		.cIm(cIm_q),
		.done(seqDone),
		.posSq(posSq),
		.negSq(negSq),
		.sumRe(sumRe),
		.sumIm(sumIm)
	);

	// Condition evaluation, valid in the seqDone cycle
	always_comb begin
		if (subtractRes) begin
			rawRe = 20'(sumRe) - 20'(resRe_q);
			rawIm = 20'(sumIm) - 20'(resIm_q);
		end else begin
			rawRe = 20'(sumRe) + 20'(resRe_q);
			rawIm = 20'(sumIm) + 20'(resIm_q);
		end
		diffRe = rawRe - compRe_q;
		diffIm = rawIm - compIm_q;
		minMag = mag_q[0];
		maxMag = mag_q[0];
		for (int i = 1; i < 3; i++) begin
			if (mag_q[i] < minMag) begin
				minMag = mag_q[i];
			end
			if (mag_q[i] > maxMag) begin
				maxMag = mag_q[i];
			end
		end
		condNow[0] = ~|overHigh_q;
		condNow[1] = |aboveLow_q;
		condNow[2] = |belowLow_q;
		condNow[3] = (32'(minMag) * 32'(ctsup_pkg::RATIO_FULL)) < (32'(minmaxRatio_q) * 32'(maxMag));
		condNow[4] = (64'(negSq) * 64'(ctsup_pkg::RATIO_FULL) * 64'(ctsup_pkg::RATIO_FULL))
			> (64'(posSq) * 64'(seqRatio_q) * 64'(seqRatio_q));
		// summed difference checked unless residual choice is RES_NONE
		if (resSel == ctsup_pkg::RES_NONE) begin
			condNow[5] = 1'b1;
		end else begin
			condNow[5] = (40'(diffRe * diffRe) + 40'(diffIm * diffIm)) > 40'(sumDiff_q * sumDiff_q);
		end
	end

	// Compensation request and capture of present difference
	// capture on next evaluation
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			compPending_q <= 1'b0;
			compRe_q <= 20'sh0_0000;
			compIm_q <= 20'sh0_0000;
		end else begin
			if (seqDone && compPending_q) begin
				compRe_q <= rawRe;
				compIm_q <= rawIm;
			end
			// A new request in the capture cycle stays pending
			if (regWrite && regAddr == ctsup_pkg::ADDR_COMMAND && regWrData[ctsup_pkg::CMD_COMP_BIT]) begin
				compPending_q <= 1'b1;
			end else if (seqDone) begin
				compPending_q <= 1'b0;
			end
		end
	end

	// Mode decode; unknown codes decode as Off, but forcing still applies to them
	// mode behaviour
	always_comb begin
		funcActive = 1'b0;
		modeBlocked = 1'b0;
		modeTest = 1'b0;
		case (modeSel)
			ctsup_pkg::MODE_ON: begin
				funcActive = 1'b1;
			end
			ctsup_pkg::MODE_TEST: begin
				funcActive = 1'b1;
				modeTest = 1'b1;
			end
			ctsup_pkg::MODE_BLOCKED: begin
				modeBlocked = 1'b1;
			end
			ctsup_pkg::MODE_TEST_BLOCKED: begin
				modeBlocked = 1'b1;
				modeTest = 1'b1;
			end
			default: begin
				funcActive = 1'b0;
			end
		endcase
	end

	// Delay timer counts sample sets while every condition holds
	// continuous hold for delay
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cond_q <= 6'h00;
			timer_q <= 19'h0_0000;
			detected_q <= 1'b0;
		end else if (seqDone) begin
			cond_q <= condNow;
			if (!funcActive || !(&condNow)) begin
				timer_q <= 19'h0_0000;
				detected_q <= 1'b0;
			end else if (timer_q >= delay_q) begin
				detected_q <= 1'b1;
			end else begin
				timer_q <= timer_q + 19'h0_0001;
			end
		end
	end

	// Status: blocked, alarm or normal, then forcing on top
	always_comb begin
		if (modeBlocked) begin
			computedStatus = ctsup_pkg::STAT_BLOCKED;
		end else if (detected_q) begin
			computedStatus = ctsup_pkg::STAT_ALARM;
		end else begin
			computedStatus = ctsup_pkg::STAT_NORMAL;
		end
		if (stageForceEnable && modeSel != ctsup_pkg::MODE_OFF && forceVal != 2'h3) begin
			finalStatus = ctsup_pkg::ctsup_status_type'(forceVal);
		end else begin
			finalStatus = computedStatus;
		end
	end

	// Outputs; test modes route the alarm to the test flag only
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			statusOut <= 2'h0;
			alarmOut <= 1'b0;
			testAlarmOut <= 1'b0;
		end else begin
			statusOut <= finalStatus;
			alarmOut <= (finalStatus == ctsup_pkg::STAT_ALARM) && !modeTest;
			testAlarmOut <= (finalStatus == ctsup_pkg::STAT_ALARM) && modeTest;
		end
	end

	// Read data one cycle after the strobe; unmapped reads give zero
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			regRdData <= 32'h0000_0000;
		end else if (regRead) begin
			if (regAddr == ctsup_pkg::ADDR_CTRL) begin
				regRdData <= 32'(ctrl_q);
			end else if (regAddr == ctsup_pkg::ADDR_HIGH_LIMIT) begin
				regRdData <= 32'(highLimit_q);
			end else if (regAddr == ctsup_pkg::ADDR_LOW_LIMIT) begin
				regRdData <= 32'(lowLimit_q);
			end else if (regAddr == ctsup_pkg::ADDR_MINMAX_RATIO) begin
				regRdData <= 32'(minmaxRatio_q);
			end else if (regAddr == ctsup_pkg::ADDR_SEQ_RATIO) begin
				regRdData <= 32'(seqRatio_q);
			end else if (regAddr == ctsup_pkg::ADDR_SUM_DIFF) begin
				regRdData <= 32'(sumDiff_q);
			end else if (regAddr == ctsup_pkg::ADDR_DELAY) begin
				regRdData <= 32'(delay_q);
			end else if (regAddr == ctsup_pkg::ADDR_STATUS) begin
				regRdData <= 32'({compPending_q, cond_q, testAlarmOut, alarmOut, statusOut});
			end else if (regAddr == ctsup_pkg::ADDR_COMP_RE) begin
				regRdData <= 32'(unsigned'(compRe_q));
			end else if (regAddr == ctsup_pkg::ADDR_COMP_IM) begin
				regRdData <= 32'(unsigned'(compIm_q));
			end else if (regAddr == ctsup_pkg::ADDR_TIMER) begin
				regRdData <= 32'(timer_q);
			end else begin
				regRdData <= 32'h0000_0000;
			end
		end
	end

endmodule

`default_nettype wire

// *** bench/ctsup_check_properties.sv ***
/*
 Port checker for the CT supervision top: alarm timing against the
 sample strobe and input patterns that can never raise an alarm.
 Assumes the high limit setting is never written above 40.00 x In.
*/
`timescale 1ns/100ps
`default_nettype none

module ctsup_check (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic sampleStrobe,
	input wire logic regWrite,
	input wire logic [15:0] phase_a_fundamental,
	input wire logic [15:0] phase_b_fundamental,
	input wire logic [15:0] phase_c_fundamental,
	input wire logic stageForceEnable,
	input wire logic alarmOut,
	input wire logic testAlarmOut,
	input wire logic [1:0] statusOut
);
	// One domain, so one clock and one reset for all
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	// Outputs move four edges after a strobe, two after a write
	AST_ALARM_RISE: assert property ($rose(alarmOut) && !stageForceEnable
		|-> $past(sampleStrobe, 4) || $past(regWrite, 2))
		else $error("alarm rose outside an evaluation");
	AST_ALARM_FALL: assert property ($fell(alarmOut) && !stageForceEnable
		|-> $past(sampleStrobe, 4) || $past(regWrite, 2))
		else $error("alarm fell outside an evaluation");
	AST_TEST_RISE: assert property ($rose(testAlarmOut) && !stageForceEnable
		|-> $past(sampleStrobe, 4) || $past(regWrite, 2))
		else $error("test alarm rose outside an evaluation");
	AST_ONE_ALARM: assert property (!(alarmOut && testAlarmOut))
		else $error("alarm and test alarm both high");
	AST_STATUS_CODE: assert property (statusOut != 2'b11)
		else $error("status code out of range");
	// Above 40.00 x In no high limit can be met
	AST_OVER_HIGH: assert property (sampleStrobe && !stageForceEnable && phase_a_fundamental > 16'h0FA0
		|-> ##4 !alarmOut && !testAlarmOut)
		else $error("alarm with a phase above any upper limit");
	AST_ALL_ZERO: assert property (sampleStrobe && !stageForceEnable
		&& {phase_a_fundamental, phase_b_fundamental, phase_c_fundamental} == 48'h0000_0000_0000
		|-> ##4 !alarmOut && !testAlarmOut)
		else $error("alarm with no phase above the lower limit");
	// Equal phases give a min/max ratio of 100 %, not below any setting up to 100.00 %
	AST_BALANCED: assert property (sampleStrobe && !stageForceEnable && phase_a_fundamental != 16'h0000
		&& phase_a_fundamental == phase_b_fundamental && phase_a_fundamental == phase_c_fundamental
		|-> ##4 !alarmOut && !testAlarmOut)
		else $error("alarm with balanced phases");
endmodule

bind ctsup_top ctsup_check u_check (.core_clk(core_clk), .sys_rst(sys_rst), .sampleStrobe(sampleStrobe),
	.phase_a_fundamental(phase_a_fundamental), .phase_b_fundamental(phase_b_fundamental),
	.phase_c_fundamental(phase_c_fundamental), .stageForceEnable(stageForceEnable),
	.regWrite(regWrite), .alarmOut(alarmOut), .testAlarmOut(testAlarmOut), .statusOut(statusOut));
`default_nettype wire

// *** bench/ctsup_channels.sv ***
/*
 Model of the phase and residual measurement channels: magnitudes at
 120 degree spacing, residual one wired as a healthy residual CT.
 Assumes magnitudes change only well away from the load edge.
*/
`timescale 1ns/100ps
`default_nettype none

module ctsup_channels #(
	parameter int PERIOD = 10
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [15:0] magA,
	input wire logic [15:0] magB,
	input wire logic [15:0] magC,
	output logic sampleStrobe,
	output logic [15:0] fundA,
	output logic [15:0] fundB,
	output logic [15:0] fundC,
	output logic signed [15:0] ph[6],
	output logic signed [15:0] res[4]
);
	int cnt; // Position in the sample period
	logic signed [15:0] sinB; // Negated imaginary part of phase b
	logic signed [15:0] sinC; // Imaginary part of phase c
	logic signed [15:0] sumRe; // Real part of the phase sum
	assign sinB = 16'((32'(magB) * 32'(ctsup_pkg::SQRT3_HALF_Q15)) >> ctsup_pkg::Q_SHIFT);
	assign sinC = 16'((32'(magC) * 32'(ctsup_pkg::SQRT3_HALF_Q15)) >> ctsup_pkg::Q_SHIFT);
	assign sumRe = 16'(magA) - 16'(magB >> 1) - 16'(magC >> 1);

	// Values load one cycle ahead so they are steady at the strobe
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt <= 0;
			sampleStrobe <= 1'b0;
		end else begin
			cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
			sampleStrobe <= (cnt == PERIOD - 2);
			if (cnt == PERIOD - 3) begin
				fundA <= magA;
				fundB <= magB;
				fundC <= magC;
				ph <= '{magA, 16'h0000, -16'(magB >> 1), -sinB, -16'(magC >> 1), sinC};
				// healthy residual one, second input dead
				res <= '{-sumRe, sinB - sinC, 16'h0000, 16'h0000};
			end
		end
	end
endmodule
`default_nettype wire

// *** bench/testbench.sv ***
/*
 Self-checking bench for the CT supervision top: register defaults,
 alarm delay, hysteresis, modes, forcing, residual source and polarity.
 Assumes the channel model strobes every ten cycles.
*/
`timescale 1ns/100ps
`default_nettype none

module testbench;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [3:0] regAddr = 4'h0;
	logic [31:0] regWrData = 32'h0000_0000;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic stageForceEnable = 1'b0;
	logic [15:0] magA = 16'h0000;
	logic [15:0] magB = 16'h0000;
	logic [15:0] magC = 16'h0000;
	logic [31:0] regRdData;
	logic sampleStrobe;
	logic [15:0] fundA, fundB, fundC;
	logic signed [15:0] ph[6];
	logic signed [15:0] res[4];
	logic alarmOut, testAlarmOut;
	logic [1:0] statusOut;
	int num_errors = 0;
	int n_compared = 0;

	// Free-running 100 MHz clock
	always #5 core_clk = ~core_clk;

	ctsup_channels #(.PERIOD(10)) u_chan (.core_clk(core_clk), .sys_rst(sys_rst), .magA(magA), .magB(magB),
		.magC(magC), .sampleStrobe(sampleStrobe), .fundA(fundA), .fundB(fundB), .fundC(fundC), .ph(ph), .res(res));

	ctsup_top u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
		.regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .sampleStrobe(sampleStrobe),
		.phase_a_fundamental(fundA), .phase_b_fundamental(fundB), .phase_c_fundamental(fundC),
		.phaseARe(ph[0]), .phaseAIm(ph[1]), .phaseBRe(ph[2]), .phaseBIm(ph[3]), .phaseCRe(ph[4]),
		.phaseCIm(ph[5]), .residualOneRe(res[0]), .residualOneIm(res[1]), .residualTwoRe(res[2]),
		.residualTwoIm(res[3]), .stageForceEnable(stageForceEnable), .alarmOut(alarmOut),
		.testAlarmOut(testAlarmOut), .statusOut(statusOut));

	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One-cycle write strobe
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge core_clk);
		regWrite <= 1'b0;
	endtask

	// Read data stands from the cycle after the strobe until the next read
	task automatic rd(input logic [3:0] a, input logic [31:0] exp);
		@(posedge core_clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge core_clk);
		regRead <= 1'b0;
		#1 chk(regRdData, exp);
	endtask

	// Let n evaluations reach the outputs
	task automatic smp(input int n);
		repeat (n) @(posedge core_clk iff sampleStrobe === 1'b1);
		repeat (4) @(posedge core_clk);
		#1;
	endtask

	// New magnitudes, placed five edges after a strobe, before the channel load
	task automatic mags(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
		smp(1);
		@(posedge core_clk);
		magA <= a;
		magB <= b;
		magC <= c;
	endtask

	// Alarm, test alarm and masked status against expectation
	task automatic outs(input logic a, input logic t, input logic [1:0] s, input logic [1:0] m);
		chk({28'h0000_000, alarmOut, testAlarmOut, statusOut & m}, {28'h0000_000, a, t, s & m});
	endtask

	// Reset values, unmapped and write-only reads
	task automatic t_defaults;
		logic [3:0] ad[9] = '{ctsup_pkg::ADDR_CTRL, ctsup_pkg::ADDR_HIGH_LIMIT, ctsup_pkg::ADDR_LOW_LIMIT,
			ctsup_pkg::ADDR_MINMAX_RATIO, ctsup_pkg::ADDR_SEQ_RATIO, ctsup_pkg::ADDR_SUM_DIFF,
			ctsup_pkg::ADDR_DELAY, ctsup_pkg::ADDR_COMMAND, 4'hF};
		logic [31:0] dv[9] = '{32'h0000_0000, 32'h0000_0078, 32'h0000_000A, 32'h0000_03E8, 32'h0000_1324,
			32'h0000_000A, 32'h0000_0064, 32'h0000_0000, 32'h0000_0000};
		for (int i = 0; i < 9; i++) begin
			rd(ad[i], dv[i]);
		end
		wr(4'hF, 32'h0000_1234);
		rd(4'hF, 32'h0000_0000);
	endtask

	// Delay count, restart on loss, upper limit hysteresis
	task automatic t_delay;
		wr(ctsup_pkg::ADDR_DELAY, 32'h0000_0002);
		rd(ctsup_pkg::ADDR_DELAY, 32'h0000_0002);
		mags(16'h0064, 16'h0000, 16'h0000);
		smp(2);
		outs(1'b0, 1'b0, 2'h0, 2'h3);
		smp(1);
		outs(1'b1, 1'b0, 2'h1, 2'h3);
		mags(16'h0064, 16'h0064, 16'h0064);
		smp(1);
		outs(1'b0, 1'b0, 2'h0, 2'h3);
		mags(16'h0064, 16'h0000, 16'h0000);
		smp(2);
		outs(1'b0, 1'b0, 2'h0, 2'h3);
		mags(16'h1000, 16'h0000, 16'h0000);
		mags(16'h0076, 16'h0000, 16'h0000);
		smp(3);
		outs(1'b0, 1'b0, 2'h0, 2'h3);
		mags(16'h0074, 16'h0000, 16'h0000);
		smp(2);
		outs(1'b0, 1'b0, 2'h0, 2'h3);
		smp(1);
		outs(1'b1, 1'b0, 2'h1, 2'h3);
	endtask

	// All five modes with a standing fault, no delay
	task automatic t_modes;
		logic [4:0] ea = 5'b00001;
		logic [4:0] et = 5'b00100;
		logic [1:0] es[5] = '{2'h1, 2'h2, 2'h1, 2'h2, 2'h0};
		wr(ctsup_pkg::ADDR_DELAY, 32'h0000_0000);
		for (int m = 0; m < 5; m++) begin
			wr(ctsup_pkg::ADDR_CTRL, 32'(m));
			smp(2);
			outs(ea[m], et[m], es[m], 2'h3);
		end
		wr(ctsup_pkg::ADDR_CTRL, 32'h0000_0000);
		smp(2);
	endtask

	// Forced status overrides the computed alarm
	task automatic t_force;
		@(posedge core_clk);
		stageForceEnable <= 1'b1;
		for (int f = 0; f < 3; f++) begin
			wr(ctsup_pkg::ADDR_CTRL, 32'(f << 3));
			smp(2);
			chk({30'h0000_0000, statusOut}, 32'(f));
		end
		wr(ctsup_pkg::ADDR_CTRL, 32'h0000_0018);
		smp(2);
		@(posedge core_clk);
		stageForceEnable <= 1'b0;
	endtask

	// Residual source, polarity, then compensation
	task automatic t_residual;
		logic [7:0] ctl[4] = '{8'h20, 8'h40, 8'hA0, 8'h60};
		logic [3:0] ea = 4'b1110;
		for (int i = 0; i < 4; i++) begin
			wr(ctsup_pkg::ADDR_CTRL, 32'(ctl[i]));
			smp(2);
			outs(ea[i], 1'b0, 2'(ea[i]), 2'h3);
		end
		wr(ctsup_pkg::ADDR_CTRL, 32'h0000_0040);
		wr(ctsup_pkg::ADDR_COMMAND, 32'h0000_0001);
		smp(3);
		outs(1'b0, 1'b0, 2'h0, 2'h3);
	endtask

	// Verdict and end of run
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Main sequence after 20 cycles of reset
	initial begin
		repeat (20) @(posedge core_clk);
		sys_rst <= 1'b0;
		t_defaults();
		t_delay();
		t_modes();
		t_force();
		t_residual();
		report_and_stop();
	end

	// Whole run needs well under 2000 sample periods
	initial begin
		#200_000;
		num_errors++;
		report_and_stop();
	end
endmodule
`default_nettype wire
